// ### rtl/mpi_pkg.sv
// package: register map, field layout and types for the monitor pin interface
package mpi_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_PIN_MODE = 8'h00;
  localparam logic [7:0] ADDR_GPIO_OUT = 8'h04;
  localparam logic [7:0] ADDR_GPIO_OE = 8'h08;
  localparam logic [7:0] ADDR_GPIO_IN = 8'h0C;
  localparam logic [7:0] ADDR_DAC_SEL = 8'h10;
  localparam logic [7:0] ADDR_GENERAL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_CONV = 8'h20;
  localparam logic [7:0] ADDR_LIMIT_A = 8'h24;
  localparam logic [7:0] ADDR_LIMIT_B = 8'h28;
  localparam logic [7:0] ADDR_SPI_RX = 8'h2C;
  localparam logic [7:0] ADDR_SPI_TX = 8'h30;
  localparam logic [7:0] ADDR_DAC_STAT = 8'h34;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MODE_BUSY = 0;
  localparam int MODE_LOAD = 1;
  localparam int MODE_OFF_A = 2;
  localparam int MODE_OFF_B = 3;
  localparam int MODE_FLAG_A = 4;
  localparam int MODE_FLAG_B = 5;
  localparam int GEN_POL = 0;
  localparam int GEN_SPI_OE = 1;
  localparam int ST_FRAME = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_LIMIT_A = 2;
  localparam int ST_LIMIT_B = 3;
  localparam int ST_CONV = 4;
  localparam int CONV_START = 0;
  localparam int CONV_DONE = 1;
  localparam int CONV_CH = 2;
  localparam int CONV_RES = 8;
  // ************************************************************
  // shared pins and reset values
  // ************************************************************
  localparam int PIN_FLAG_A = 0;
  localparam int PIN_FLAG_B = 1;
  localparam int PIN_OFF_A = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_OFF_B = 4;
  localparam int PIN_BUSY = 6;
  localparam int NUM_GPIO = 12;
  localparam int NUM_DAC = 4;
  localparam int RES_W = 10;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } mpi_spi_in_t;

  typedef struct packed {
    logic sdo_o;
    logic sdo_oe;
  } mpi_spi_out_t;

  typedef struct packed {
    logic [RES_W-1:0] high;
    logic [RES_W-1:0] low;
  } mpi_limit_t;

  typedef enum logic [1:0] {
    MPI_CV_IDLE = 2'b00,
    MPI_CV_RUN = 2'b01
  } mpi_conv_t;
endpackage

// ### rtl/mpi_top.sv
// design: spi pins, shared gpio pins and alternate functions of the monitor
`timescale 1ns/1ps
`default_nettype none
module mpi_top #(
  parameter int CONV_CYCLES = 238
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mpi_pkg::mpi_spi_in_t spi_in,
  output mpi_pkg::mpi_spi_out_t spi_out,
  input wire logic [mpi_pkg::NUM_GPIO-1:0] gpio_i,
  output logic [mpi_pkg::NUM_GPIO-1:0] gpio_o,
  output logic [mpi_pkg::NUM_GPIO-1:0] gpio_oe,
  output logic [mpi_pkg::NUM_DAC-1:0] dac_enable,
  output logic dac_update,
  output logic irq
);
  import mpi_pkg::*;

  // ************************************************************
  // pin synchronisers: three stages, edge when stages 2 and 3 agree
  // ************************************************************
  logic [2:0] cs_s_r, ck_s_r, di_s_r;
  logic [NUM_GPIO-1:0] g1_r, g2_r, g3_r;
  logic cs_n_r, sclk_r, sclk_prev_r;

  always_ff @(posedge aclk) begin
    cs_s_r <= {cs_s_r[1:0], spi_in.cs_n};
    ck_s_r <= {ck_s_r[1:0], spi_in.sclk};
    di_s_r <= {di_s_r[1:0], spi_in.sdi};
    g1_r <= gpio_i;
    g2_r <= g1_r;
    g3_r <= g2_r;
    if (!aresetn) begin
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      if (cs_s_r[1] == cs_s_r[2]) cs_n_r <= cs_s_r[2];
      if (ck_s_r[1] == ck_s_r[2]) sclk_r <= ck_s_r[2];
      sclk_prev_r <= sclk_r;
    end
  end

  logic [NUM_GPIO-1:0] gpio_in_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) gpio_in_r <= '0;
    else gpio_in_r <= (g2_r & g3_r) | (gpio_in_r & (g2_r | g3_r));
  end

  wire sclk_fall = sclk_prev_r & ~sclk_r;
  wire sclk_rise = ~sclk_prev_r & sclk_r;

  // ************************************************************
  // registers
  // ************************************************************
  logic [5:0] pin_mode_r;
  logic [NUM_GPIO-1:0] gpio_out_r, gpio_dir_r;
  logic [NUM_DAC-1:0] sel_a_r, sel_b_r;
  logic [1:0] gen_r;
  logic [4:0] status_r, mask_r;
  mpi_limit_t lim_a_r, lim_b_r;
  logic [31:0] spi_rx_r, spi_tx_r;
  logic [RES_W-1:0] result_r;
  logic chan_r;
  mpi_conv_t conv_st_r;
  logic [15:0] conv_cnt_r;
  logic conv_done_r;

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  function automatic logic hit(input logic [7:0] a);
    unique case (a)
      ADDR_PIN_MODE, ADDR_GPIO_OUT, ADDR_GPIO_OE, ADDR_GPIO_IN,
      ADDR_DAC_SEL, ADDR_GENERAL, ADDR_STATUS, ADDR_MASK, ADDR_CONV,
      ADDR_LIMIT_A, ADDR_LIMIT_B, ADDR_SPI_RX, ADDR_SPI_TX,
      ADDR_DAC_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= RST_ZERO;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] wv;
  assign wv = merge(RST_ZERO, w_data_r, w_strb_r);
  function automatic logic wr_at(input logic [7:0] a, input logic go,
                                 input logic [7:0] at);
    wr_at = go && (a == at);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_mode_r <= '0;
      gpio_out_r <= '0;
      gpio_dir_r <= '0;
      sel_a_r <= '0;
      sel_b_r <= '0;
      gen_r <= '0;
      mask_r <= '0;
      lim_a_r <= '0;
      lim_b_r <= '0;
      spi_tx_r <= RST_ZERO;
    end else begin
      if (wr_at(aw_addr_r, wr_go, ADDR_PIN_MODE)) pin_mode_r <= wv[5:0];
      if (wr_at(aw_addr_r, wr_go, ADDR_GPIO_OUT))
        gpio_out_r <= wv[NUM_GPIO-1:0];
      if (wr_at(aw_addr_r, wr_go, ADDR_GPIO_OE))
        gpio_dir_r <= wv[NUM_GPIO-1:0];
      if (wr_at(aw_addr_r, wr_go, ADDR_DAC_SEL)) begin
        sel_a_r <= wv[3:0];
        sel_b_r <= wv[11:8];
      end
      if (wr_at(aw_addr_r, wr_go, ADDR_GENERAL)) gen_r <= wv[1:0];
      if (wr_at(aw_addr_r, wr_go, ADDR_MASK)) mask_r <= wv[4:0];
      if (wr_at(aw_addr_r, wr_go, ADDR_LIMIT_A)) lim_a_r <= {wv[25:16], wv[9:0]};
      if (wr_at(aw_addr_r, wr_go, ADDR_LIMIT_B)) lim_b_r <= {wv[25:16], wv[9:0]};
      if (wr_at(aw_addr_r, wr_go, ADDR_SPI_TX)) spi_tx_r <= w_data_r;
    end
  end

  // ************************************************************
  // conversion sequencing and limit compare
  // ************************************************************
  wire conv_start = wr_at(aw_addr_r, wr_go, ADDR_CONV) & wv[CONV_START];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_st_r <= MPI_CV_IDLE;
      conv_cnt_r <= '0;
      result_r <= '0;
      chan_r <= 1'b0;
    end else begin
      unique case (conv_st_r)
        MPI_CV_IDLE: if (conv_start) begin
          conv_st_r <= MPI_CV_RUN;
          conv_cnt_r <= 16'(CONV_CYCLES - 1);
          result_r <= wv[CONV_RES +: RES_W];
          chan_r <= wv[CONV_CH];
        end
        MPI_CV_RUN: if (conv_cnt_r == '0) conv_st_r <= MPI_CV_IDLE;
          else conv_cnt_r <= conv_cnt_r - 16'h0001;
      endcase
    end
  end
  wire conv_busy = (conv_st_r == MPI_CV_RUN);
  always_ff @(posedge aclk) begin
    if (!aresetn) conv_done_r <= 1'b0;
    else conv_done_r <= conv_busy && conv_cnt_r == '0;
  end

  function automatic logic out_of_range(input logic [RES_W-1:0] v,
                                        input mpi_limit_t l);
    out_of_range = (v > l.high) || (v < l.low);
  endfunction
  logic viol_a_r, viol_b_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      viol_a_r <= 1'b0;
      viol_b_r <= 1'b0;
    end else if (conv_done_r) begin
      viol_a_r <= !chan_r && out_of_range(result_r, lim_a_r);
      viol_b_r <= chan_r && out_of_range(result_r, lim_b_r);
    end
  end

  // ************************************************************
  // spi slave: cs frames, fall samples, rise shifts
  // ************************************************************
  logic [31:0] sh_out_r;
  logic [5:0] bit_cnt_r;
  logic sdo_r;
  logic frame_end;
  logic cs_prev_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_rx_r <= RST_ZERO;
      sh_out_r <= RST_ZERO;
      bit_cnt_r <= '0;
      sdo_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_n_r;
      if (cs_prev_r && !cs_n_r) begin
        sh_out_r <= spi_tx_r;
        sdo_r <= spi_tx_r[31];
        bit_cnt_r <= '0;
      end else if (!cs_n_r) begin
        if (sclk_fall) begin
          spi_rx_r <= {spi_rx_r[30:0], di_s_r[2]};
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
        if (sclk_rise && bit_cnt_r != '0) begin
          sh_out_r <= {sh_out_r[30:0], 1'b0};
          sdo_r <= sh_out_r[30];
        end
      end
    end
  end
  assign frame_end = !cs_prev_r && cs_n_r;
  // released outside a frame or when read return is off
  assign spi_out = '{sdo_o: sdo_r,
                     sdo_oe: !cs_n_r && gen_r[GEN_SPI_OE]};

  // ************************************************************
  // shared pins
  // ************************************************************
  wire pol = gen_r[GEN_POL];
  logic load_prev_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) load_prev_r <= 1'b0;
    else load_prev_r <= gpio_in_r[PIN_LOAD];
  end
  wire load_rise = pin_mode_r[MODE_LOAD] & gpio_in_r[PIN_LOAD] & ~load_prev_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) dac_update <= 1'b0;
    else dac_update <= load_rise;
  end

  wire off_a = pin_mode_r[MODE_OFF_A] & gpio_in_r[PIN_OFF_A];
  wire off_b = pin_mode_r[MODE_OFF_B] & gpio_in_r[PIN_OFF_B];
  always_ff @(posedge aclk) begin
    if (!aresetn) dac_enable <= '1;
    else dac_enable <= ~((off_a ? sel_a_r : '0)
                       | (off_b ? sel_b_r : '0));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_o <= '0;
      gpio_oe <= '0;
    end else begin
      gpio_o <= gpio_out_r;
      gpio_oe <= gpio_dir_r;
      // output alternate functions replace gpio value and enable; input ones only clear the enable
      if (pin_mode_r[MODE_BUSY]) begin
        gpio_o[PIN_BUSY] <= conv_busy;
        gpio_oe[PIN_BUSY] <= 1'b1;
      end
      if (pin_mode_r[MODE_FLAG_A]) begin
        gpio_o[PIN_FLAG_A] <= viol_a_r ^ ~pol;
        gpio_oe[PIN_FLAG_A] <= 1'b1;
      end
      if (pin_mode_r[MODE_FLAG_B]) begin
        gpio_o[PIN_FLAG_B] <= viol_b_r ^ ~pol;
        gpio_oe[PIN_FLAG_B] <= 1'b1;
      end
      if (pin_mode_r[MODE_LOAD]) gpio_oe[PIN_LOAD] <= 1'b0;
      if (pin_mode_r[MODE_OFF_A]) gpio_oe[PIN_OFF_A] <= 1'b0;
      if (pin_mode_r[MODE_OFF_B]) gpio_oe[PIN_OFF_B] <= 1'b0;
    end
  end

  // ************************************************************
  // interrupts: sticky, write one to clear, set wins
  // ************************************************************
  // alert events judged on the fresh result, not the flags still updating
  wire [4:0] ev = {conv_done_r,
                   conv_done_r & chan_r & out_of_range(result_r, lim_b_r),
                   conv_done_r & !chan_r & out_of_range(result_r, lim_a_r),
                   load_rise, frame_end};
  wire [4:0] clr = wr_at(aw_addr_r, wr_go, ADDR_STATUS) ? wv[4:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) status_r <= '0;
    else status_r <= (status_r & ~clr) | ev;
  end
  assign irq = |(status_r & mask_r);

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_PIN_MODE: s_axi_rdata <= {26'h0, pin_mode_r};
        ADDR_GPIO_OUT: s_axi_rdata <= {20'h0, gpio_out_r};
        ADDR_GPIO_OE: s_axi_rdata <= {20'h0, gpio_dir_r};
        ADDR_GPIO_IN: s_axi_rdata <= {20'h0, gpio_in_r};
        ADDR_DAC_SEL: s_axi_rdata <= {20'h0, sel_b_r, 4'h0, sel_a_r};
        ADDR_GENERAL: s_axi_rdata <= {30'h0, gen_r};
        ADDR_STATUS: s_axi_rdata <= {27'h0, status_r};
        ADDR_MASK: s_axi_rdata <= {27'h0, mask_r};
        ADDR_CONV: s_axi_rdata <= {14'h0, result_r, 5'h0, chan_r,
                                   conv_done_r, conv_busy};
        ADDR_LIMIT_A: s_axi_rdata <= {6'h0, lim_a_r.high, 6'h0, lim_a_r.low};
        ADDR_LIMIT_B: s_axi_rdata <= {6'h0, lim_b_r.high, 6'h0, lim_b_r.low};
        ADDR_SPI_RX: s_axi_rdata <= spi_rx_r;
        ADDR_SPI_TX: s_axi_rdata <= spi_tx_r;
        ADDR_DAC_STAT: s_axi_rdata <= {28'h0, dac_enable};
        default: s_axi_rdata <= RST_ZERO;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verification/mpi_top_properties.sv
// checker: pin and bus relations of the monitor pin interface
`timescale 1ns/1ps
`default_nettype none
module mpi_top_properties
  import mpi_pkg::*;
#(
  parameter int CONV_CYCLES = 238
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire mpi_pkg::mpi_spi_in_t spi_in,
  input wire mpi_pkg::mpi_spi_out_t spi_out,
  input wire logic [mpi_pkg::NUM_GPIO-1:0] gpio_i,
  input wire logic [mpi_pkg::NUM_GPIO-1:0] gpio_o,
  input wire logic [mpi_pkg::NUM_DAC-1:0] dac_enable,
  input wire logic dac_update
);
  import mpi_pkg::*;
  logic [15:0] busy_cnt_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ************************************************************
  // helper: length of the current busy pulse
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !gpio_o[PIN_BUSY]) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  sdo_release_a: assert property (spi_in.cs_n [*5] |-> !spi_out.sdo_oe)
    else $error("data out driven outside a frame");
  sdo_steady_a: assert property (
    (!spi_in.cs_n && spi_in.sclk) [*6] |=> $stable(spi_out.sdo_o))
    else $error("data out moved without a clock rise");
  load_quiet_a: assert property (!gpio_i[PIN_LOAD] [*8] |-> !dac_update)
    else $error("dac update without a load pin rise");
  load_pulse_a: assert property (dac_update |=> !dac_update)
    else $error("dac update longer than one cycle");
  dac_on_a: assert property (
    (!gpio_i[PIN_OFF_A] && !gpio_i[PIN_OFF_B]) [*8] |-> dac_enable == 4'hF)
    else $error("dac off with both disable pins idle");
  busy_bound_a: assert property (busy_cnt_r <= CONV_CYCLES + 2)
    else $error("busy pin outlasts a conversion");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rvalid_time_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule
bind mpi_top mpi_top_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .spi_in(spi_in), .spi_out(spi_out),
  .gpio_i(gpio_i), .gpio_o(gpio_o), .dac_enable(dac_enable),
  .dac_update(dac_update)
);
`default_nettype wire

// ### verification/mpi_spi_host.sv
// partner: behavioural serial host that frames words for the monitor
`timescale 1ns/1ps
`default_nettype none
module mpi_spi_host (
  output mpi_pkg::mpi_spi_in_t spi_in,
  input wire mpi_pkg::mpi_spi_out_t spi_out
);
  import mpi_pkg::*;
  logic [31:0] rx_r;
  initial begin
    spi_in = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
  end
  // clock stands low between frames; a released line reads inverted
  task automatic xfer(input logic [31:0] tx, input logic frame);
    logic line;
    spi_in.cs_n = !frame;
    #62.5;
    for (int i = 31; i >= 0; i--) begin
      spi_in.sdi = tx[i];
      spi_in.sclk = 1'b1;
      #62.5;
      line = spi_out.sdo_oe ? spi_out.sdo_o : ~spi_out.sdo_o;
      rx_r = {rx_r[30:0], line};
      spi_in.sclk = 1'b0;
      #62.5;
    end
    spi_in.cs_n = 1'b1;
    spi_in.sdi = !spi_in.sdi;
    #62.5;
  endtask
endmodule
`default_nettype wire

// ### verification/mpi_top_tb.sv
// testbench: register, serial and shared pin scenarios of the monitor
`timescale 1ns/1ps
`default_nettype none
module mpi_top_tb;
  import mpi_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, dac_update;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] rresp, bresp;
  logic [11:0] gpio_i, gpio_o, gpio_oe;
  logic [3:0] dac_enable;
  mpi_spi_in_t spi_in;
  mpi_spi_out_t spi_out;
  logic [33:0] exp_q[$];
  int err_total, tests_run;
  logic [9:0] lims[4] = '{10'd99, 10'd100, 10'd200, 10'd201};
  mpi_top #(.CONV_CYCLES(10)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .spi_in(spi_in), .spi_out(spi_out),
    .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .dac_enable(dac_enable), .dac_update(dac_update), .irq(irq)
  );
  mpi_spi_host host (.spi_in(spi_in), .spi_out(spi_out));
  always #2 aclk = ~aclk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ************************************************************
  // bus tasks: handshakes judged just before the taking edge
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [2:0] hs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hs = 3'h0;
    while (hs != 3'h7) begin
      @(negedge aclk);
      hs = hs | {awready & awvalid, wready & wvalid, bvalid & bready};
      @(posedge aclk);
      if (hs[2]) awvalid <= 1'b0;
      if (hs[1]) wvalid <= 1'b0;
      if (hs[0]) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    logic [1:0] hs;
    @(posedge aclk);
    exp_q.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs = 2'h0;
    while (hs != 2'h3) begin
      @(negedge aclk);
      hs = hs | {arready & arvalid, rvalid & rready};
      @(posedge aclk);
      if (hs[1]) arvalid <= 1'b0;
      if (hs[0]) rready <= 1'b0;
    end
  endtask
  // read results are matched against the oldest note
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      cmp({rresp, rdata}, exp_q.pop_front());
  end
  task automatic conv(input int ch, input logic [9:0] r);
    int n;
    n = 0;
    wr(ADDR_CONV, {14'h0, r, 5'h0, ch[0], 2'h1});
    @(negedge aclk);
    cmp({33'h0, gpio_oe[PIN_BUSY]}, 34'h1);
    while (gpio_o[PIN_BUSY] === 1'b1 && n < 500) begin
      @(negedge aclk);
      n++;
    end
    cmp({33'h0, n > 2 && n <= 10}, 34'h1);
    repeat (3) @(negedge aclk);
  endtask
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata, gpio_i} = '0;
    err_total = 0;
    tests_run = 0;
    seed = xs(32'h41C9);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h3C, {RESP_SLVERR, 32'h0});
    wr(8'h3C, 32'h0);
    @(negedge aclk);
    cmp({32'h0, bresp}, {32'h0, RESP_SLVERR});
    wr(ADDR_MASK, 32'h0);
    @(negedge aclk);
    cmp({32'h0, bresp}, {32'h0, RESP_OKAY});
    rd(ADDR_DAC_STAT, {RESP_OKAY, 32'hF});
    wr(ADDR_GENERAL, 32'h3);
    wr(ADDR_SPI_TX, seed);
    wr(ADDR_STATUS, 32'h1F);
    wr(ADDR_MASK, 32'h1);
    host.xfer(~seed, 1'b1);
    repeat (8) @(posedge aclk);
    cmp({2'h0, host.rx_r}, {2'h0, seed});
    cmp({33'h0, spi_out.sdo_oe}, 34'h0);
    rd(ADDR_SPI_RX, {RESP_OKAY, ~seed});
    @(negedge aclk);
    cmp({33'h0, irq}, 34'h1);
    wr(ADDR_MASK, 32'h0);
    @(negedge aclk);
    cmp({33'h0, irq}, 34'h0);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_MASK, 32'h1);
    @(negedge aclk);
    cmp({33'h0, irq}, 34'h0);
    host.xfer(seed, 1'b0);
    rd(ADDR_SPI_RX, {RESP_OKAY, ~seed});
    wr(ADDR_PIN_MODE, 32'h3F);
    wr(ADDR_DAC_SEL, 32'h0000_0C03);
    wr(ADDR_LIMIT_A, 32'h00C8_0064);
    wr(ADDR_LIMIT_B, 32'h00C8_0064);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_GENERAL, {31'h0, p[0]});
      for (int k = 0; k < 4; k++) begin
        conv(k % 2, lims[k]);
        cmp({33'h0, gpio_o[k % 2]}, {33'h0, (k == 0 || k == 3) ^ !p[0]});
      end
    end
    wr(ADDR_STATUS, 32'h1F);
    gpio_i[PIN_LOAD] <= 1'b1;
    @(negedge aclk);
    while (dac_update !== 1'b1 && tests_run < 1000) @(negedge aclk);
    cmp({33'h0, dac_update}, 34'h1);
    cmp({33'h0, gpio_oe[PIN_LOAD]}, 34'h0);
    @(posedge aclk);
    gpio_i[PIN_LOAD] <= 1'b0;
    rd(ADDR_STATUS, {RESP_OKAY, 32'h2});
    for (int k = 1; k < 5; k++) begin
      gpio_i[PIN_OFF_A] <= k[0];
      gpio_i[PIN_OFF_B] <= k[1];
      repeat (8) @(posedge aclk);
      rd(ADDR_DAC_STAT, {RESP_OKAY, 28'h0, ~{k[1], k[1], k[0], k[0]}});
    end
    seed = xs(seed);
    gpio_i <= seed[11:0] & 12'hFE3;
    repeat (8) @(posedge aclk);
    rd(ADDR_GPIO_IN, {RESP_OKAY, 20'h0, seed[11:0] & 12'hFE3});
    wr(ADDR_PIN_MODE, 32'h0);
    wr(ADDR_GPIO_OE, 32'hFFF);
    wr(ADDR_GPIO_OUT, seed & 32'hFBF);
    repeat (2) @(negedge aclk);
    cmp({10'h0, gpio_oe, gpio_o}, {10'h0, 12'hFFF, seed[11:0] & 12'hFBF});
    conclude();
  end
endmodule
`default_nettype wire
